// ===== rtl/line_code_regs.svh
`ifndef LINE_CODE_REGS_SVH
`define LINE_CODE_REGS_SVH

// ==========================================================
// Ternary symbol codes
`define TERN_ZERO   2'h0
`define TERN_POS    2'h1
`define TERN_NEG    2'h3
`define TERN_BAD    2'h2

// ==========================================================
// Bit clock phases (master clock divided by four)
`define PH_RISE     2'h1
`define PH_HIGH     2'h2
`define PH_FALL     2'h3
`define PH_LOW      2'h0

// ==========================================================
// Reset states, buffer depth and synchroniser width
`define PRE_INIT    1'h1
`define BIT_INIT    1'h0
`define POL_INIT    1'h0
`define FIFO_DEPTH  8
`define SYNC_W      9

`endif

// ===== rtl/line_code_pkg.sv
package line_code_pkg;

    // Signed ternary symbol: negative, zero or positive
    typedef logic [1:0] tern_t;

    // All encoder outputs, produced side by side
    typedef struct packed {
        tern_t nrzl;
        tern_t nrzm;
        tern_t unirz;
        tern_t biprz;
        tern_t ami;
        tern_t biol;
        tern_t dicode;
        tern_t duob;
    } enc_out_s;

    // Waveform selected at the decoder input
    typedef enum logic [2:0] {
        FMT_NRZL,
        FMT_NRZM,
        FMT_UNIRZ,
        FMT_BIPRZ,
        FMT_AMI,
        FMT_BIOL,
        FMT_DICODE,
        FMT_DUOB
    } fmt_e;

endpackage

// ===== rtl/line_code_codec_pair.sv
`timescale 1ns/10ps
`include "line_code_regs.svh"

// ==========================================================
// Two-flop synchroniser
module pin_sync #(
    parameter int W = 1
) (
    input  logic         mclk,
    input  logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_r;

    always_ff @(posedge mclk) begin
        meta_r <= din;
        dout   <= meta_r;
    end
endmodule

// ==========================================================
// Bit buffer in front of the encoder
module bit_fifo #(
    parameter int W = 1,
    parameter int D = 8
) (
    // Clock and reset
    input  logic         mclk,
    input  logic         srst,
    // Fill side
    input  logic [W-1:0] in_data,
    input  logic         in_valid,
    output logic         in_ready,
    // Drain side
    output logic [W-1:0] out_data,
    output logic         out_valid,
    input  logic         out_ready
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(D);
    localparam logic [AW-1:0] LAST_PTR = AW'(D - 1);

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [CW-1:0] count_r;
    logic [CW-1:0] count_nxt;
    logic          push;
    logic          pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_valid = (count_r != '0);
    assign out_data  = mem[rd_ptr_r];
    assign count_nxt = count_r + CW'(push) - CW'(pop);

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
            in_ready <= 1'h0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'h1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'h1;
            end
            count_r  <= count_nxt;
            in_ready <= (count_nxt != FULL_CNT);
        end
    end
endmodule

// ==========================================================
// Operation
// R01 - Dicode: bit change gives a pulse opposite to the last pulse
// R02 - Dicode: unchanged bit gives the zero level for that bit
// R03 - Precoded bit is input xor previous precoded bit, starts at one
// R04 - Duobinary symbol is sum of current and previous bipolar precoded bits
// R05 - All line codes are produced in parallel from one input stream
// R06 - Controller resets the encoder again after master clock loss; the code has no clock-loss detection and resets only on its reset inputs
// R07 - Only one encoded waveform is fed to the decoder at a time
// R08 - Decoder bit clock is aligned, symbol boundaries on falling edges
// R09 - Strobe output is generated directly from the decoder bit clock
// R10 - Decoder samples on strobe rise, data valid right after
// R11 - Decoder is reset after bit clock or waveform is applied
// R12 - Decoder reset output drives encoder reset; either button resets both
// R13 - Unlinked reset: hold encoder, pulse decoder, then release encoder
// R14 - Decoder state starts from the encoder's initial state after reset
// R15 - Decoder recovers data from every format the encoder makes
// R16 - Encoder bit clock is the master clock divided by four
// R17 - Source changes data on bit clock rise; symbol from next fall
// R18 - Three-level outputs are two-bit signed ternary symbols
module line_code_codec_pair #(
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    // Clock and reset
    input  logic                   mclk,
    input  logic                   resetn,
    // Reset buttons and reset link
    input  logic                   enc_rst_btn,
    input  logic                   dec_rst_btn,
    input  logic                   enc_rst_in,
    output logic                   dec_rst_out,
    // Bit source
    input  logic                   src_data,
    input  logic                   src_valid,
    output logic                   src_ready,
    // Encoder line side
    output logic                   enc_bclk,
    output line_code_pkg::enc_out_s enc_out,
    // Decoder line side
    input  logic                   dec_bclk,
    input  line_code_pkg::tern_t   dec_line,
    input  line_code_pkg::fmt_e    dec_fmt,
    output logic                   dec_strobe,
    output logic                   dec_data
);
    import line_code_pkg::*;

    // ======================================================
    // Pin synchronisers and resets
    logic [`SYNC_W-1:0] pins_s;
    logic               enc_btn_s;
    logic               dec_btn_s;
    logic               enc_in_s;
    logic               bclk_s;
    tern_t              line_s;
    fmt_e               fmt_s;
    logic               enc_rst;
    logic               dec_rst;

    pin_sync #(.W(`SYNC_W)) u_sync (
        .mclk (mclk),
        .din  ({enc_rst_btn, dec_rst_btn, enc_rst_in, dec_bclk,
                dec_line, dec_fmt}),
        .dout (pins_s)
    );

    assign {enc_btn_s, dec_btn_s, enc_in_s, bclk_s} = pins_s[8:5];
    assign line_s  = pins_s[4:3];
    assign fmt_s   = fmt_e'(pins_s[2:0]);
    // Encoder button resets both ends; decoder button resets the encoder only through the reset link
    assign enc_rst = !resetn || enc_btn_s || enc_in_s; // R12
    assign dec_rst = !resetn || dec_btn_s || enc_btn_s; // R11 R12

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            dec_rst_out <= 1'h0;
        end else begin
            dec_rst_out <= dec_btn_s || enc_btn_s; // R12
        end
    end

    // ======================================================
    // Encoder: bit clock and source buffer
    logic [1:0] ph_r;
    logic       next_bit_r;
    logic       fifo_bit;
    logic       fifo_valid;
    logic       at_rise;
    logic       at_fall;

    assign at_rise = (ph_r == `PH_RISE);
    assign at_fall = (ph_r == `PH_FALL);

    bit_fifo #(.W(1), .D(FIFO_DEPTH)) u_fifo (
        .mclk      (mclk),
        .srst      (enc_rst),
        .in_data   (src_data),
        .in_valid  (src_valid),
        .in_ready  (src_ready),
        .out_data  (fifo_bit),
        .out_valid (fifo_valid),
        .out_ready (at_rise)
    );

    always_ff @(posedge mclk) begin
        if (enc_rst) begin
            ph_r       <= `PH_LOW;
            enc_bclk   <= 1'h0;
            next_bit_r <= `BIT_INIT;
        end else begin
            ph_r     <= ph_r + 2'h1; // R16
            enc_bclk <= (ph_r == `PH_RISE) || (ph_r == `PH_HIGH); // R16
            if (at_rise) begin
                // Empty buffer sends zeros
                next_bit_r <= fifo_valid && fifo_bit; // R17
            end
        end
    end

    // ======================================================
    // Encoder: symbol formation
    function automatic tern_t bip(input logic b);
        return b ? `TERN_POS : `TERN_NEG;
    endfunction

    logic     enc_bit_r;
    logic     nrzm_lvl_r;
    logic     ami_pol_r;
    logic     dic_pol_r;
    logic     pre_r;
    logic     upd_r;
    logic     x;
    logic     chg;
    logic     nrzm_lvl_nxt;
    logic     ami_pol_nxt;
    logic     dic_pol_nxt;
    logic     pre_nxt;
    tern_t    duob_sym;
    enc_out_s full_sym;
    enc_out_s half_sym;

    assign x            = next_bit_r;
    assign chg          = x ^ enc_bit_r;
    assign nrzm_lvl_nxt = nrzm_lvl_r ^ x;
    assign ami_pol_nxt  = x ? !ami_pol_r : ami_pol_r;
    assign dic_pol_nxt  = chg ? !dic_pol_r : dic_pol_r; // R01
    assign pre_nxt      = x ^ pre_r; // R03
    assign duob_sym     = (pre_nxt && pre_r)   ? `TERN_POS :
                          (!pre_nxt && !pre_r) ? `TERN_NEG :
                                                 `TERN_ZERO; // R04

    // Full-bit symbols, all from the same input bit
    assign full_sym.nrzl   = bip(x); // R05
    assign full_sym.nrzm   = bip(nrzm_lvl_nxt);
    assign full_sym.unirz  = x ? `TERN_POS : `TERN_ZERO;
    assign full_sym.biprz  = bip(x);
    assign full_sym.ami    = x ? bip(ami_pol_nxt) : `TERN_ZERO;
    assign full_sym.biol   = bip(x);
    assign full_sym.dicode = chg ? bip(dic_pol_nxt) : `TERN_ZERO; // R01 R02
    assign full_sym.duob   = duob_sym; // R04 R18

    // Second half of the bit: return to zero, biphase inverts
    assign half_sym.nrzl   = enc_out.nrzl;
    assign half_sym.nrzm   = enc_out.nrzm;
    assign half_sym.unirz  = `TERN_ZERO;
    assign half_sym.biprz  = `TERN_ZERO;
    assign half_sym.ami    = `TERN_ZERO;
    assign half_sym.biol   = bip(!enc_bit_r);
    assign half_sym.dicode = enc_out.dicode;
    assign half_sym.duob   = enc_out.duob;

    always_ff @(posedge mclk) begin
        if (enc_rst) begin
            enc_bit_r  <= `BIT_INIT;
            nrzm_lvl_r <= `POL_INIT;
            ami_pol_r  <= `POL_INIT;
            dic_pol_r  <= `POL_INIT;
            pre_r      <= `PRE_INIT; // R03
            upd_r      <= 1'h0;
            enc_out    <= '0;
        end else begin
            upd_r <= at_fall;
            if (at_fall) begin
                enc_bit_r  <= x;
                nrzm_lvl_r <= nrzm_lvl_nxt;
                ami_pol_r  <= ami_pol_nxt;
                dic_pol_r  <= dic_pol_nxt;
                pre_r      <= pre_nxt;
                enc_out    <= full_sym; // R05 R17
            end else if (at_rise) begin
                enc_out    <= half_sym;
            end
        end
    end

    // ======================================================
    // Decoder: strobe from bit clock, sample on its rise
    logic  bclk_d_r;
    logic  fall_d_r;
    logic  dec_rise;
    logic  dec_fall;
    tern_t first_r;
    logic  prev_lvl_r;
    logic  dec_prev_r;
    logic  dec_bit;
    logic  first_pos;
    logic  first_nz;

    assign dec_rise  = bclk_s && !bclk_d_r;
    assign dec_fall  = !bclk_s && bclk_d_r;
    assign first_pos = (first_r == `TERN_POS);
    assign first_nz  = (first_r != `TERN_ZERO);

    // Bit recovery per waveform format
    always_comb begin
        case (fmt_s)
            FMT_NRZL:   dec_bit = (line_s == `TERN_POS);
            FMT_NRZM:   dec_bit = first_pos ^ prev_lvl_r;
            FMT_UNIRZ:  dec_bit = first_pos;
            FMT_BIPRZ:  dec_bit = first_pos;
            FMT_AMI:    dec_bit = first_nz;
            FMT_BIOL:   dec_bit = first_pos;
            FMT_DICODE: dec_bit = first_nz ? !dec_prev_r : dec_prev_r;
            FMT_DUOB:   dec_bit = (line_s == `TERN_ZERO);
            default:    dec_bit = 1'h0;
        endcase
    end // R15

    always_ff @(posedge mclk) begin
        if (dec_rst) begin
            bclk_d_r   <= 1'h0;
            fall_d_r   <= 1'h0;
            first_r    <= `TERN_ZERO;
            prev_lvl_r <= `POL_INIT; // R14
            dec_prev_r <= `BIT_INIT; // R14
            dec_strobe <= 1'h0;
            dec_data   <= 1'h0;
        end else begin
            bclk_d_r   <= bclk_s;
            fall_d_r   <= dec_fall;
            dec_strobe <= bclk_s; // R09
            // First-half level, taken just after the symbol boundary
            if (fall_d_r) begin
                first_r <= line_s;
            end
            if (dec_rise) begin
                dec_data   <= dec_bit; // R10
                prev_lvl_r <= first_pos;
                dec_prev_r <= dec_bit;
            end
        end
    end

    // ======================================================
    // Checks
    a_bclk_div4: assert property (@(posedge mclk) disable iff (enc_rst) // R16
        $rose(enc_bclk) |=> enc_bclk ##1 !enc_bclk ##1 !enc_bclk ##1 enc_bclk)
        else $error("bit clock is not master clock over four");

    a_dicode_pulse: assert property (@(posedge mclk) disable iff (enc_rst) // R01
        upd_r && (enc_bit_r != $past(enc_bit_r)) |->
            (dic_pol_r != $past(dic_pol_r)) && (enc_out.dicode == bip(dic_pol_r)))
        else $error("dicode pulse polarity did not alternate");

    a_dicode_zero: assert property (@(posedge mclk) disable iff (enc_rst) // R02
        upd_r && (enc_bit_r == $past(enc_bit_r)) |->
            (enc_out.dicode == `TERN_ZERO) ##1 (enc_out.dicode == `TERN_ZERO))
        else $error("dicode not zero for unchanged bit");

    a_precode_sum: assert property (@(posedge mclk) disable iff (enc_rst) // R03
        upd_r |-> pre_r == (enc_bit_r ^ $past(pre_r)))
        else $error("precoded bit is not a modulo-2 sum");

    a_precode_init: assert property (@(posedge mclk) disable iff (!resetn) // R03
        enc_rst |=> pre_r)
        else $error("precoded state not one after reset");

    a_duob_level: assert property (@(posedge mclk) disable iff (enc_rst) // R04
        upd_r |-> enc_out.duob == ((pre_r == $past(pre_r)) ?
            bip(pre_r) : `TERN_ZERO))
        else $error("duobinary symbol is not the sum of bipolar bits");

    a_parallel_out: assert property (@(posedge mclk) disable iff (enc_rst) // R05
        upd_r |-> (enc_out.nrzl == bip(enc_bit_r)) &&
            (enc_out.biol == bip(enc_bit_r)) &&
            (enc_out.unirz == (enc_bit_r ? `TERN_POS : `TERN_ZERO))
            ##2 (enc_out.biol == bip(!enc_bit_r)))
        else $error("line codes not produced together");

    a_symbol_edge: assert property (@(posedge mclk) disable iff (enc_rst) // R17
        $changed(enc_out) |-> ($past(ph_r) == `PH_FALL) ||
            ($past(ph_r) == `PH_RISE))
        else $error("symbol changed away from a bit clock edge");

    a_tern_legal: assert property (@(posedge mclk) disable iff (enc_rst) // R18
        (enc_out.dicode != `TERN_BAD) && (enc_out.duob != `TERN_BAD) &&
            (enc_out.ami != `TERN_BAD))
        else $error("illegal ternary code");

    a_strobe_src: assert property (@(posedge mclk) disable iff (dec_rst) // R09
        $rose(bclk_s) |=> dec_strobe ##1 (dec_strobe == $past(bclk_s)))
        else $error("strobe does not follow bit clock");

    a_sample_rise: assert property (@(posedge mclk) disable iff (dec_rst) // R10
        $rose(dec_strobe) |-> dec_data == $past(dec_bit))
        else $error("decoded bit not sampled on strobe rise");

    a_rst_link: assert property (@(posedge mclk) disable iff (!resetn) // R12
        (dec_btn_s || enc_btn_s) |=> dec_rst_out && !dec_prev_r)
        else $error("reset output or decoder state wrong on reset");

endmodule

// ===== tb/line_patch.sv
`timescale 1ns/10ps
// ==========================================================
// Patch lead from one encoder output to the decoder input
module line_patch (
    // Clock and pacing
    input  logic                    mclk,
    input  logic                    slow,
    // Encoder side
    input  logic                    bclk_in,
    input  line_code_pkg::enc_out_s codes,
    input  line_code_pkg::fmt_e     fmt,
    // Decoder side
    output logic                    bclk_out,
    output line_code_pkg::tern_t    line_out
);
    import line_code_pkg::*;

    logic [15:0] flat;
    tern_t       pick;
    logic        bclk_r;
    tern_t       line_r;

    assign flat = codes;
    // Only the selected waveform reaches the decoder
    assign pick = flat[{3'h7 - fmt, 1'b0} +: 2];

    // A slow lead delays clock and symbol alike, so they stay aligned
    always_ff @(posedge mclk) begin
        bclk_r <= bclk_in;
        line_r <= pick;
    end

    assign bclk_out = slow ? bclk_r : bclk_in;
    assign line_out = slow ? line_r : pick;
endmodule

// ===== tb/line_code_codec_pair_bench.sv
`timescale 1ns/10ps
`include "line_code_regs.svh"
module line_code_codec_pair_bench;
    import line_code_pkg::*;

    localparam logic [7:0] HDR = 8'hb4;

    logic        mclk, resetn, enc_rst_btn, dec_rst_btn, enc_rst_in;
    logic        dec_rst_out, src_data, src_valid, src_ready, enc_bclk;
    logic        dec_bclk, dec_strobe, dec_data, slow, linked, armed;
    logic        rdy_seen, ebp, started, pb, pol, u, b, sp, locked;
    logic        lv, ap, hv;
    logic [7:0]  sh;
    logic [31:0] r;
    enc_out_s    enc_out;
    tern_t       dec_line;
    fmt_e        dec_fmt;
    int          miscompares, total_checks, cyc, n, per, hi;
    int          seed = 32'hd891;
    logic        enc_q[$];
    logic        dec_q[$];

    // Reset lead between the two units, unplugged for manual resets
    assign enc_rst_in = linked & dec_rst_out;

    line_code_codec_pair i_dut (
        .mclk(mclk), .resetn(resetn), .enc_rst_btn(enc_rst_btn),
        .dec_rst_btn(dec_rst_btn), .enc_rst_in(enc_rst_in),
        .dec_rst_out(dec_rst_out), .src_data(src_data),
        .src_valid(src_valid), .src_ready(src_ready),
        .enc_bclk(enc_bclk), .enc_out(enc_out), .dec_bclk(dec_bclk),
        .dec_line(dec_line), .dec_fmt(dec_fmt),
        .dec_strobe(dec_strobe), .dec_data(dec_data)
    );

    line_patch i_patch (
        .mclk(mclk), .slow(slow), .bclk_in(enc_bclk), .codes(enc_out),
        .fmt(dec_fmt), .bclk_out(dec_bclk), .line_out(dec_line)
    );

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // ==========================================================
    // Compare and report
    task automatic check_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic check_tern(input tern_t got, input tern_t exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: symbol %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        if (miscompares == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ==========================================================
    // Drivers
    always @(negedge mclk) rdy_seen <= src_ready;

    task automatic send_bit(input logic bit_v, input logic to_dec);
        int k;
        k = 0;
        src_data  <= bit_v;
        src_valid <= 1'b1;
        do begin
            @(posedge mclk);
            k++;
        end while (!rdy_seen && k < 100);
        enc_q.push_back(bit_v);
        if (to_dec) dec_q.push_back(bit_v);
    endtask

    // Method 0: reset pin, 1: linked decoder button, 2: manual sequence,
    // 3: linked encoder button
    task automatic reset_pair(input int m);
        armed  <= 1'b0;
        linked <= (m != 2);
        if (m == 0) begin
            resetn <= 1'b0;
            repeat (4) @(posedge mclk);
            resetn <= 1'b1;
        end else begin
            enc_rst_btn <= (m >= 2);
            dec_rst_btn <= (m != 3);
            n = 0;
            do begin
                @(negedge mclk);
                n++;
            end while (dec_rst_out !== 1'b1 && n < 10);
            check_bit(dec_rst_out, 1'b1);
            repeat (5) @(negedge mclk);
            check_bit(enc_bclk, 1'b0);
            check_bit(src_ready, 1'b0);
            @(posedge mclk);
            dec_rst_btn <= 1'b0;
            repeat (6) @(posedge mclk);
            enc_rst_btn <= 1'b0;
        end
        repeat (12) @(posedge mclk);
        enc_q.delete();
        dec_q.delete();
        armed <= 1'b1;
    endtask

    // ==========================================================
    // Encoder watcher: symbols land where the bit clock falls
    always @(negedge mclk) begin
        per = per + 1;
        if (enc_bclk) hi = hi + 1;
        if (!armed) begin
            started = 1'b0;
            lv = 1'b0;
            ap = 1'b0;
            hv = 1'b0;
            pb = 1'b0;
            pol = 1'b0;
            u = 1'b1;
        end
        if (armed && ebp && !enc_bclk) begin
            if (started) begin
                check_bit(logic'(per == 4), 1'b1);
                check_bit(logic'(hi == 2), 1'b1);
            end
            if (enc_out.nrzl === `TERN_POS) started = 1'b1;
            if (started && enc_q.size() > 0) begin
                b = enc_q.pop_front();
                check_tern(enc_out.nrzl, b ? `TERN_POS : `TERN_NEG);
                check_tern(enc_out.biprz, b ? `TERN_POS : `TERN_NEG);
                check_tern(enc_out.unirz, b ? `TERN_POS : `TERN_ZERO);
                check_tern(enc_out.biol, b ? `TERN_POS : `TERN_NEG);
                if (b != pb) pol = ~pol;
                check_tern(enc_out.dicode, b == pb ? `TERN_ZERO :
                           pol ? `TERN_POS : `TERN_NEG);
                check_tern(enc_out.duob, b ? `TERN_ZERO :
                           u ? `TERN_POS : `TERN_NEG);
                lv = lv ^ b;
                check_tern(enc_out.nrzm, lv ? `TERN_POS : `TERN_NEG);
                if (b) ap = ~ap;
                check_tern(enc_out.ami, !b ? `TERN_ZERO :
                           ap ? `TERN_POS : `TERN_NEG);
                hv = 1'b1;
                u = u ^ b;
                pb = b;
            end
        end
        // Second half: return to zero, biphase inverts
        if (armed && !ebp && enc_bclk && hv) begin
            hv = 1'b0;
            check_tern(enc_out.unirz, `TERN_ZERO);
            check_tern(enc_out.biprz, `TERN_ZERO);
            check_tern(enc_out.ami, `TERN_ZERO);
            check_tern(enc_out.biol, pb ? `TERN_NEG : `TERN_POS);
        end
        if (ebp && !enc_bclk) begin
            per = 0;
            hi = 0;
        end
        ebp = enc_bclk;
    end

    // ==========================================================
    // Decoder watcher: locks on the header, then checks each bit
    always @(negedge mclk) begin
        if (!armed) begin
            sh = 8'h00;
            locked = 1'b0;
        end else if (dec_strobe && !sp) begin
            if (locked && dec_q.size() > 0)
                check_bit(dec_data, dec_q.pop_front());
            else if (!locked) begin
                sh = {sh[6:0], dec_data};
                locked = (sh == HDR);
            end
        end
        sp = dec_strobe;
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            complete_run;
        end
    end

    // ==========================================================
    // Main sequence: every format, each reset method, both leads
    initial begin
        resetn = 1'b0;
        enc_rst_btn = 1'b0;
        dec_rst_btn = 1'b0;
        src_data = 1'b0;
        src_valid = 1'b0;
        slow = 1'b0;
        linked = 1'b1;
        armed = 1'b0;
        dec_fmt = FMT_NRZL;
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        for (int f = 0; f < 8; f++) begin
            dec_fmt <= fmt_e'(f);
            slow    <= f[0];
            reset_pair(f == 4 ? 3 : f % 3);
            // Back-to-back pushes fill the buffer until it refuses
            for (int i = 0; i < 32; i++) begin
                r = $random(seed);
                send_bit(i < 8 ? HDR[7 - i] : r[0], i >= 8);
            end
            src_valid <= 1'b0;
            n = 0;
            while ((enc_q.size() > 0 || dec_q.size() > 0) && n < 600) begin
                @(posedge mclk);
                n++;
            end
            check_bit(logic'(enc_q.size() + dec_q.size() == 0), 1'b1);
        end
        complete_run;
    end
endmodule
